//--- common/rtc_defines.svh
// register offsets, field positions, reset values and crc polynomials of the rx timing/crc bank
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_OFS_RX_INPUT     8'h1e
`define RTC_OFS_QUAD_CLOCK   8'h1f
`define RTC_OFS_GUARD        8'h21
`define RTC_OFS_CRC_MODE     8'h22
`define RTC_OFS_START_LOW    8'h23
`define RTC_OFS_START_HIGH   8'h24
`define RTC_OFS_IRQ_STATUS   8'h2a
`define RTC_OFS_IRQ_MASK     8'h2b
`define RTC_RST_RX_INPUT     8'h41
`define RTC_RST_GUARD        8'h08
`define RTC_RST_CRC_MODE     8'h0c
`define RTC_RST_START_LOW    8'hfe
`define RTC_RST_START_HIGH   8'hff
`define RTC_RST_QUAD_DELAY   5'h10
`define RTC_BIT_INPHASE      7
`define RTC_BIT_AUTOPD       6
`define RTC_BIT_Q180         7
`define RTC_BIT_CALDIS       6
`define RTC_BIT_MSB_ORDER    6
`define RTC_BIT_STD_POLY     5
`define RTC_BIT_BYTE_WIDTH   4
`define RTC_BIT_RX_CHK       3
`define RTC_BIT_TX_CHK       2
`define RTC_IRQ_CRC_ERR      0
`define RTC_IRQ_CAL_DONE     1
`define RTC_IRQ_GUARD_END    2
`define RTC_POLY_LEGACY      16'h1021
`define RTC_POLY_STD         16'h8408
`define RTC_POLY_8           8'h1d
`endif

//--- common/rtc_pkg.sv
// types shared by the rx timing/crc bank
package rtc_pkg;
    typedef enum logic [1:0] {
        RTC_IDLE  = 2'b00,
        RTC_GUARD = 2'b01,
        RTC_RECV  = 2'b10,
        RTC_CAL   = 2'b11
    } rtc_state_type;
    typedef enum logic [1:0] {
        RTC_SRC_LOW   = 2'b00,
        RTC_SRC_DEMOD = 2'b01
    } rtc_src_type;
endpackage

//--- hw/rtc_bank.sv
// rx timing and crc control register bank with crc engine and guard timer
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "rtc_defines.svh"
// How it works
// - inphase bit 1 picks I clock, else Q
// - auto powerdown gates receiver around reception
// - decoder source 00 low, 01 demodulator
// - read-only flag shows Q beyond half turn
// - calibrate after reset and reception unless disabled
// - delay element count set by calibration or host
// - guard time after transmit ignores receive input
// - order bit 1 shifts msb first
// - standard polynomial bit picks 3309 crc
// - width bit 1 gives 8-bit crc
// - receive check flags mismatch, hides crc bytes
// - transmit enable appends crc bytes
// - low preset loaded at each crc start
// - high preset loaded likewise, ignored in 8-bit
module rtc_bank #(
    parameter int CAL_CYCLES = 32
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    // register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [7:0]       reg_rdata_out,
    // frame control from transceiver
    input  wire logic        tx_start_in,
    input  wire logic        tx_end_in,
    input  wire logic        rx_start_in,
    input  wire logic        rx_end_in,
    input  wire logic        compute_cmd_in,
    input  wire logic        bit_clk_in,
    // byte stream through the crc unit
    input  wire logic [7:0]  data_in,
    input  wire logic        data_valid_in,
    input  wire logic        data_last_in,
    output logic [7:0]       data_out,
    output logic             data_valid_out,
    // analog front end
    input  wire logic        demod_pin_in,
    input  wire logic        q_phase_over_in,
    input  wire logic        cal_phase_ok_in,
    output logic             rx_clk_inphase_out,
    output logic             rx_power_on_out,
    output logic             decoder_in_out,
    output logic [4:0]       quad_delay_out,
    output logic [15:0]      crc_value_out,
    output logic             irq_out
);
    // =====================================================
    // registers
    logic [7:0]  rx_ctl_r;
    logic        cal_dis_r;
    logic [4:0]  qdelay_r;
    logic [7:0]  guard_r;
    logic [7:0]  crc_mode_r;
    logic [7:0]  start_lo_r;
    logic [7:0]  start_hi_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_mask_r;
    logic [2:0]  dsync_r;
    logic [2:0]  qsync_r;
    logic        q180_r;
    logic        demod_r;
    rtc_pkg::rtc_state_type state_r;
    logic [7:0]  guard_cnt_r;
    logic [7:0]  cal_cnt_r;
    logic        cal_pend_r;
    logic [15:0] crc_r;
    logic [15:0] crc_nxt;
    logic [15:0] hold_r;
    logic [1:0]  hold_cnt_r;
    logic        tx_mode_r;
    logic [1:0]  app_cnt_r;
    logic        crc_err_ev;
    logic        wr_sel;
    logic        stat_rd;
    logic        dec_src;
    logic [2:0]  irq_evt;

    wire logic eight = crc_mode_r[`RTC_BIT_BYTE_WIDTH];

    // one byte through the crc register, lsb or msb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                             input logic [7:0] mode);
        logic [15:0] v;
        logic        b;
        v = c;
        for (int i = 0; i < 8; i++) begin
            b = mode[`RTC_BIT_MSB_ORDER] ? d[7 - i] : d[i];
            if (mode[`RTC_BIT_BYTE_WIDTH]) begin
                v[7:0] = {v[6:0], 1'b0} ^ ((v[7] ^ b) ? `RTC_POLY_8 : 8'h00);
                v[15:8] = 8'h00;
            end else if (mode[`RTC_BIT_STD_POLY]) begin
                v = {1'b0, v[15:1]} ^ ((v[0] ^ b) ? `RTC_POLY_STD : 16'h0000);
            end else begin
                v = {v[14:0], 1'b0} ^ ((v[15] ^ b) ? `RTC_POLY_LEGACY : 16'h0000);
            end
        end
        return v;
    endfunction

    function automatic logic [15:0] crc_start(input logic [7:0] hi, input logic [7:0] lo,
                                              input logic e8);
        return e8 ? {8'h00, lo} : {hi, lo};
    endfunction

    // =====================================================
    // register writes
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rx_ctl_r   <= `RTC_RST_RX_INPUT;
            guard_r    <= `RTC_RST_GUARD;
            crc_mode_r <= `RTC_RST_CRC_MODE;
            start_lo_r <= `RTC_RST_START_LOW;
            start_hi_r <= `RTC_RST_START_HIGH;
            irq_mask_r <= 3'h0;
            cal_dis_r  <= 1'b0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `RTC_OFS_RX_INPUT) begin
                rx_ctl_r <= reg_wdata_in;
            end else if (reg_addr_in == `RTC_OFS_QUAD_CLOCK) begin
                cal_dis_r <= reg_wdata_in[`RTC_BIT_CALDIS];
            end else if (reg_addr_in == `RTC_OFS_GUARD) begin
                guard_r <= reg_wdata_in;
            end else if (reg_addr_in == `RTC_OFS_CRC_MODE) begin
                crc_mode_r <= {1'b0, reg_wdata_in[6:2], 2'b00};
            end else if (reg_addr_in == `RTC_OFS_START_LOW) begin
                start_lo_r <= reg_wdata_in;
            end else if (reg_addr_in == `RTC_OFS_START_HIGH) begin
                start_hi_r <= reg_wdata_in;
            end else if (reg_addr_in == `RTC_OFS_IRQ_MASK) begin
                irq_mask_r <= reg_wdata_in[2:0];
            end
        end
    end

    assign wr_sel = reg_wr_in && (reg_addr_in == `RTC_OFS_QUAD_CLOCK);

    // =====================================================
    // pin synchronisers: change accepted when stages two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            dsync_r <= 3'h0;
            qsync_r <= 3'h0;
            demod_r <= 1'b0;
            q180_r  <= 1'b0;
        end else begin
            dsync_r <= {dsync_r[1:0], demod_pin_in};
            qsync_r <= {qsync_r[1:0], q_phase_over_in};
            if (dsync_r[2] == dsync_r[1]) begin
                demod_r <= dsync_r[2];
            end
            if (qsync_r[2] == qsync_r[1]) begin
                q180_r <= qsync_r[2];
            end
        end
    end

    // =====================================================
    // sequencer: guard, reception, calibration
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_r     <= rtc_pkg::RTC_IDLE;
            guard_cnt_r <= 8'h00;
            cal_cnt_r   <= 8'h00;
            cal_pend_r  <= 1'b1;
            qdelay_r    <= `RTC_RST_QUAD_DELAY;
        end else begin
            if (wr_sel) begin
                qdelay_r <= reg_wdata_in[4:0];
            end
            case (state_r)
                rtc_pkg::RTC_IDLE: begin
                    if (tx_end_in) begin
                        state_r     <= rtc_pkg::RTC_GUARD;
                        guard_cnt_r <= guard_r;
                    end else if (cal_pend_r && !cal_dis_r) begin
                        state_r    <= rtc_pkg::RTC_CAL;
                        cal_cnt_r  <= 8'(CAL_CYCLES);
                        cal_pend_r <= 1'b0;
                    end else if (cal_dis_r) begin
                        cal_pend_r <= 1'b0;
                    end
                end
                rtc_pkg::RTC_GUARD: begin
                    if (guard_cnt_r == 8'h00) begin
                        state_r <= rtc_pkg::RTC_RECV;
                    // only bit clock pulses count, so the guard scales with the coder rate
                    end else if (bit_clk_in) begin
                        guard_cnt_r <= guard_cnt_r - 8'h01;
                    end
                end
                rtc_pkg::RTC_RECV: begin
                    if (rx_end_in) begin
                        state_r    <= rtc_pkg::RTC_IDLE;
                        cal_pend_r <= 1'b1;
                    end
                end
                rtc_pkg::RTC_CAL: begin
                    if (cal_cnt_r == 8'h00 || cal_phase_ok_in) begin
                        state_r <= rtc_pkg::RTC_IDLE;
                    end else begin
                        cal_cnt_r <= cal_cnt_r - 8'h01;
                        // a host write to the delay wins over the calibration step
                        if (!wr_sel) begin
                            qdelay_r <= qdelay_r + 5'h01;
                        end
                    end
                end
                default: state_r <= rtc_pkg::RTC_IDLE;
            endcase
        end
    end

    // =====================================================
    // receive path outputs
    // reserved source codes behave like the constant-low source
    always_comb begin
        dec_src = 1'b0;
        case (rx_ctl_r[1:0])
            2'(rtc_pkg::RTC_SRC_LOW):   dec_src = 1'b0;
            2'(rtc_pkg::RTC_SRC_DEMOD): dec_src = demod_r;
            default:                    dec_src = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rx_clk_inphase_out <= 1'b1;
            rx_power_on_out    <= 1'b0;
            decoder_in_out     <= 1'b0;
            quad_delay_out     <= `RTC_RST_QUAD_DELAY;
        end else begin
            rx_clk_inphase_out <= rx_ctl_r[`RTC_BIT_INPHASE];
            // powered for the guard as well so the front end settles before data
            rx_power_on_out    <= !rx_ctl_r[`RTC_BIT_AUTOPD] ||
                                  (state_r == rtc_pkg::RTC_GUARD) ||
                                  (state_r == rtc_pkg::RTC_RECV);
            // during the guard the pin is ignored
            decoder_in_out     <= dec_src && (state_r == rtc_pkg::RTC_RECV);
            quad_delay_out     <= qdelay_r;
        end
    end

    // =====================================================
    // crc engine
    assign crc_nxt = crc_byte(crc_r, data_in, crc_mode_r);

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            crc_r          <= 16'hfffe;
            hold_r         <= 16'h0000;
            hold_cnt_r     <= 2'h0;
            tx_mode_r      <= 1'b0;
            app_cnt_r      <= 2'h0;
            data_out       <= 8'h00;
            data_valid_out <= 1'b0;
            crc_err_ev     <= 1'b0;
        end else begin
            data_valid_out <= 1'b0;
            crc_err_ev     <= 1'b0;
            // a start pulse wins over a byte arriving in the same cycle
            if (tx_start_in || rx_start_in || compute_cmd_in) begin
                crc_r      <= crc_start(start_hi_r, start_lo_r, eight);
                tx_mode_r  <= tx_start_in;
                hold_cnt_r <= 2'h0;
                app_cnt_r  <= 2'h0;
            end else if (app_cnt_r != 2'h0) begin
                data_out       <= (app_cnt_r == 2'h2) ? crc_r[7:0] : crc_r[15:8];
                data_valid_out <= 1'b1;
                app_cnt_r      <= app_cnt_r - 2'h1;
                // crc_r is left alone so the high byte is still there for the last slot
            end else if (data_valid_in) begin
                crc_r <= crc_nxt;
                if (tx_mode_r || !crc_mode_r[`RTC_BIT_RX_CHK]) begin
                    data_out       <= data_in;
                    data_valid_out <= 1'b1;
                    if (tx_mode_r && crc_mode_r[`RTC_BIT_TX_CHK] && data_last_in) begin
                        app_cnt_r <= eight ? 2'h1 : 2'h2;
                        crc_r     <= eight ? {crc_nxt[7:0], 8'h00} : crc_nxt;
                    end
                end else begin
                    // trailing crc bytes are delayed so they never reach the fifo
                    hold_r <= {hold_r[7:0], data_in};
                    if (eight ? (hold_cnt_r != 2'h0) : (hold_cnt_r == 2'h2)) begin
                        data_out       <= eight ? hold_r[7:0] : hold_r[15:8];
                        data_valid_out <= 1'b1;
                    end
                    if (hold_cnt_r != 2'h2) begin
                        hold_cnt_r <= hold_cnt_r + 2'h1;
                    end
                    if (data_last_in) begin
                        crc_err_ev <= eight ? (crc_nxt[7:0] != 8'h00)
                                            : (crc_nxt != 16'h0000);
                    end
                end
            end
        end
    end

    // =====================================================
    // interrupt status, cleared by read, set wins
    assign stat_rd = reg_rd_in && (reg_addr_in == `RTC_OFS_IRQ_STATUS);

    always_comb begin
        irq_evt                     = 3'h0;
        irq_evt[`RTC_IRQ_CRC_ERR]   = crc_err_ev;
        irq_evt[`RTC_IRQ_CAL_DONE]  = (state_r == rtc_pkg::RTC_CAL) &&
                                      (cal_cnt_r == 8'h00 || cal_phase_ok_in);
        irq_evt[`RTC_IRQ_GUARD_END] = (state_r == rtc_pkg::RTC_GUARD) &&
                                      (guard_cnt_r == 8'h00);
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            irq_stat_r <= 3'h0;
            irq_out    <= 1'b0;
        end else begin
            // an event in the same cycle as the clearing read survives it
            irq_stat_r <= (stat_rd ? 3'h0 : irq_stat_r) | irq_evt;
            irq_out    <= |(irq_stat_r & irq_mask_r);
        end
    end

    // =====================================================
    // copy of the running crc for the front end
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            crc_value_out <= 16'h0000;
        end else begin
            crc_value_out <= crc_r;
        end
    end

    // =====================================================
    // register reads, unmapped reads return zero
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else begin
            if (!reg_rd_in) begin
                reg_rdata_out <= 8'h00;
            end else if (reg_addr_in == `RTC_OFS_RX_INPUT) begin
                reg_rdata_out <= rx_ctl_r;
            end else if (reg_addr_in == `RTC_OFS_QUAD_CLOCK) begin
                reg_rdata_out <= {q180_r, cal_dis_r, 1'b0, qdelay_r};
            end else if (reg_addr_in == `RTC_OFS_GUARD) begin
                reg_rdata_out <= guard_r;
            end else if (reg_addr_in == `RTC_OFS_CRC_MODE) begin
                reg_rdata_out <= crc_mode_r;
            end else if (reg_addr_in == `RTC_OFS_START_LOW) begin
                reg_rdata_out <= start_lo_r;
            end else if (reg_addr_in == `RTC_OFS_START_HIGH) begin
                reg_rdata_out <= start_hi_r;
            end else if (reg_addr_in == `RTC_OFS_IRQ_STATUS) begin
                reg_rdata_out <= {5'h00, irq_stat_r};
            end else if (reg_addr_in == `RTC_OFS_IRQ_MASK) begin
                reg_rdata_out <= {5'h00, irq_mask_r};
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end
endmodule

//--- testbench/rtc_bank_asserts.sv
// concurrent checks on the ports of the rx timing/crc bank
`timescale 1ns/1ps
module rtc_bank_asserts #(
    parameter int CAL_CYCLES = 32
) (
    // clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_n_in,
    // register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    // frame events and front end
    input wire logic        tx_start_in,
    input wire logic        tx_end_in,
    input wire logic        rx_clk_inphase_out,
    input wire logic        rx_power_on_out,
    input wire logic        decoder_in_out,
    input wire logic [4:0]  quad_delay_out,
    input wire logic [15:0] crc_value_out,
    input wire logic        irq_out
);
    // shadows of what software wrote, so each output can be tied to its cause
    logic [7:0] src_r, gd_r, md_r, lo_r, hi_r, qd_r;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            src_r <= 8'h41;
            gd_r <= 8'h08;
            md_r <= 8'h0c;
            lo_r <= 8'hfe;
            hi_r <= 8'hff;
            qd_r <= 8'h00;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                8'h1e: src_r <= reg_wdata_in;
                8'h1f: qd_r <= reg_wdata_in;
                8'h21: gd_r <= reg_wdata_in;
                8'h22: md_r <= reg_wdata_in;
                8'h23: lo_r <= reg_wdata_in;
                8'h24: hi_r <= reg_wdata_in;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_wr(logic [7:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    // outputs lag the register by up to two edges, so wait for it to settle
    sequence s_settled;
        $stable(src_r) [*3];
    endsequence
    sequence s_quiet;
        !decoder_in_out [*6];
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not zero outside answer cycle");
    chk_inphase_sel: assert property (s_settled |-> rx_clk_inphase_out == src_r[7])
        else $error("receiver clock choice wrong");
    chk_power_always: assert property (s_settled ##0 !src_r[6] |-> rx_power_on_out)
        else $error("receiver off with auto power-down clear");
    chk_source_low: assert property (s_settled ##0 src_r[1:0] == 2'b00 |-> !decoder_in_out)
        else $error("decoder input not low");
    chk_delay_write: assert property (s_wr(8'h1f) ##0 reg_wdata_in[6]
        |-> ##2 quad_delay_out == qd_r[4:0])
        else $error("delay count not taken from host");
    chk_mask_quiet: assert property (s_wr(8'h2b) ##0 reg_wdata_in == 8'h00 |-> ##2 !irq_out)
        else $error("interrupt high with all masked");
    chk_guard_quiet: assert property (tx_end_in && gd_r >= 8'h08 |-> ##2 s_quiet)
        else $error("decoder active during guard time");
    chk_preset_wide: assert property (tx_start_in && md_r[2] && !md_r[4]
        |-> ##[1:2] crc_value_out == {hi_r, lo_r})
        else $error("16-bit preset not loaded");
    chk_preset_byte: assert property (tx_start_in && md_r[2] && md_r[4]
        |-> ##[1:2] crc_value_out == {8'h00, lo_r})
        else $error("8-bit preset not loaded");
endmodule
bind rtc_bank rtc_bank_asserts #(.CAL_CYCLES(CAL_CYCLES)) rtc_bank_asserts_i (.ref_clk_in,
    .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .tx_start_in, .tx_end_in, .rx_clk_inphase_out, .rx_power_on_out, .decoder_in_out,
    .quad_delay_out, .crc_value_out, .irq_out);

//--- testbench/rtc_label_model.sv
// label on the far side of the rf channel, as seen at the demodulator pin
`timescale 1ns/1ps
module rtc_label_model (
    // clock and control from the bench
    input  wire logic ref_clk_in,
    input  wire logic talk_in,
    input  wire logic level_in,
    // demodulated label signal
    output logic      demod_pin_out
);
    initial demod_pin_out = 1'b0;
    // a silent label leaves the line floating: keep it moving, never parked
    always @(posedge ref_clk_in) begin
        if (talk_in) begin
            demod_pin_out <= level_in;
        end else begin
            demod_pin_out <= ~demod_pin_out;
        end
    end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the rx timing/crc bank
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        dv = 1'b0;
    logic        dl = 1'b0;
    logic        qph = 1'b0;
    logic        talk = 1'b0;
    logic        lvl = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdat = 8'h00;
    logic [7:0]  dat = 8'h00;
    logic [7:0]  v = 8'h00;
    logic [5:0]  ev = 6'h00;
    logic [7:0]  rdata, dout;
    logic        demod, dvo, inph, pwr, dec, irq;
    logic [4:0]  qdel;
    logic [15:0] crcv;
    logic [7:0]  got[$];
    int          pay[$];
    int          mdl[256];
    int          ra[9] = '{8'h1e, 8'h21, 8'h22, 8'h23, 8'h24, 8'h2b, 8'h2a, 8'h2a, 8'h30};
    int          sts = 0;
    int          miscompares = 0;
    int          n_checks = 0;

    rtc_bank #(.CAL_CYCLES(4)) rtc_bank_i (.ref_clk_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .tx_start_in(ev[0]), .tx_end_in(ev[1]), .rx_start_in(ev[2]),
        .rx_end_in(ev[3]), .compute_cmd_in(ev[5]), .bit_clk_in(ev[4]), .data_in(dat),
        .data_valid_in(dv), .data_last_in(dl), .data_out(dout), .data_valid_out(dvo),
        .demod_pin_in(demod), .q_phase_over_in(qph), .cal_phase_ok_in(1'b0),
        .rx_clk_inphase_out(inph), .rx_power_on_out(pwr), .decoder_in_out(dec),
        .quad_delay_out(qdel), .crc_value_out(crcv), .irq_out(irq));
    rtc_label_model rtc_label_model_i (.ref_clk_in(clk), .talk_in(talk), .level_in(lvl),
        .demod_pin_out(demod));

    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (dvo === 1'b1) got.push_back(dout);
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic int wmask(int a);
        case (a)
            8'h1e, 8'h21, 8'h23, 8'h24, 8'h2b: return 8'hff;
            8'h1f: return 8'h5f;
            8'h22: return 8'h7c;
            default: return 8'h00;
        endcase
    endfunction
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        mdl[a] = d & wmask(a);
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        logic [7:0] e;
        e = (a == 8'h2a) ? sts[7:0] : mdl[a][7:0] | {a == 8'h1f && qph, 7'h00};
        if (a == 8'h2a) sts = 0;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, e);
    endtask
    // reflected polynomial shifted lsb first, preset from the two start registers
    function automatic int crc16(int q[$]);
        int c;
        c = {mdl[8'h24][7:0], mdl[8'h23][7:0]};
        foreach (q[i]) begin
            c ^= q[i];
            repeat (8) c = (c & 1) ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return c;
    endfunction
    // kind 0 transmit, 1 receive with 16-bit check, 2 receive with 8-bit check
    task automatic frame(input int kind, input int bad);
        int q[$];
        pay.delete();
        got.delete();
        repeat (3) pay.push_back($urandom_range(255));
        q = pay;
        if (kind > 0) q.push_back((crc16(pay) & 8'hff) ^ bad);
        if (kind == 1) q.push_back(crc16(pay) >> 8);
        pulse(kind > 0 ? 2 : 0);
        repeat (3) @(posedge clk);
        foreach (q[i]) begin
            dat <= 8'(q[i]);
            dv <= 1'b1;
            dl <= (i == q.size() - 1);
            @(posedge clk);
        end
        dv <= 1'b0;
        dl <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // the whole sequence needs some 400 cycles; 25 times that means a hang
    initial begin
        #1_000_000;
        miscompares++;
        wrap_up();
    end

    initial begin
        void'($urandom(17));
        foreach (mdl[i]) mdl[i] = 0;
        mdl[8'h1e] = 8'h41;
        mdl[8'h21] = 8'h08;
        mdl[8'h22] = 8'h0c;
        mdl[8'h23] = 8'hfe;
        mdl[8'h24] = 8'hff;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(inph, 1'b1);
        check(qdel, 5'h10);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        sts = 2;
        foreach (ra[i]) rreg(ra[i]);
        wreg(8'h30, 8'hff);
        wreg(8'h22, 8'hff);
        rreg(8'h30);
        rreg(8'h22);
        wreg(8'h1f, 8'h40 | 8'($urandom_range(31)));
        rreg(8'h1f);
        @(posedge clk);
        qph <= 1'b1;
        repeat (6) @(posedge clk);
        rreg(8'h1f);
        @(posedge clk);
        qph <= 1'b0;
        for (int c = 1; c >= 0; c--) begin
            v = c ? 8'h41 : 8'h80;
            wreg(8'h1e, v);
            wreg(8'h1f, {1'b0, c[0], 6'h0a});
            talk <= 1'b0;
            pulse(1);
            for (int k = 0; k < 8; k++) begin
                pulse(4);
                @(negedge clk);
                check(dec, 1'b0);
            end
            @(posedge clk);
            talk <= 1'b1;
            lvl <= 1'b1;
            repeat (10) @(posedge clk);
            @(negedge clk);
            check(dec, v[0]);
            check(pwr, 1'b1);
            check(inph, v[7]);
            pulse(3);
            repeat (10) @(posedge clk);
            @(negedge clk);
            check(pwr, !v[6]);
            if (c) check(qdel, 5'h0a);
            sts = c ? 4 : 6;
            rreg(8'h2a);
        end
        wreg(8'h23, 8'hff);
        for (int m = 0; m < 9; m++) begin
            v = (m < 8) ? {1'b0, m[2:0], 4'h4} : 8'h20;
            wreg(8'h22, v);
            frame(0, 0);
            check(16'(got.size()), 16'(3 + (v[2] ? (v[4] ? 1 : 2) : 0)));
            check(got[0], pay[0]);
            if (v == 8'h24) check(got[3], crc16(pay) & 8'hff);
            if (v == 8'h24) check(got[4], crc16(pay) >> 8);
        end
        wreg(8'h22, 8'h28);
        wreg(8'h2b, 8'h01);
        frame(1, 0);
        check(16'(got.size()), 16'h0003);
        check(got[2], pay[2]);
        frame(1, 8'h5a);
        @(negedge clk);
        check(irq, 1'b1);
        sts = 1;
        rreg(8'h2a);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(irq, 1'b0);
        wreg(8'h2b, 8'h00);
        wreg(8'h22, 8'h18);
        frame(2, 0);
        check(16'(got.size()), 16'h0003);
        pulse(5);
        @(posedge clk);
        @(negedge clk);
        check(crcv, {8'h00, 8'(mdl[8'h23])});
        wrap_up();
    end
endmodule
